// File: tone_gen_defs.svh
// offsets, field positions and reset values of the tone generator
`ifndef TONE_GEN_DEFS_SVH
`define TONE_GEN_DEFS_SVH

// ************************************************************
// register indices and byte addresses
// ************************************************************
`define TONE_DIVIDER_IDX      8'h8f
`define TONE_CONTROL_IDX      8'h9f
`define TONE_DIVIDER_ADDR     10'h23c
`define TONE_CONTROL_ADDR     10'h27c
`define TONE_ADDR_W           10

// ************************************************************
// fields and reset values
// ************************************************************
`define TONE_EN_BIT           0
`define TONE_CKSEL_LO         1
`define TONE_CKSEL_HI         2
`define TONE_DIVIDER_RESET    8'hff
`define TONE_CONTROL_RESET    8'h00
`define TONE_CONTROL_MASK     8'h07

// ************************************************************
// prescaler: 256 is the widest tap, so 8 bits
// ************************************************************
`define TONE_PRESC_W          8
`define TONE_RESP_OKAY        2'h0
`define TONE_RESP_SLVERR      2'h2

`endif

// File: tone_gen_pkg.sv
// types shared by the tone generator
package tone_gen_pkg;

  // ************************************************************
  // prescaler tap codes
  // ************************************************************
  typedef enum logic [1:0] {
    TAP_DIV32,
    TAP_DIV64,
    TAP_DIV128,
    TAP_DIV256
  } tap_sel_t;

endpackage : tone_gen_pkg

// File: square_wave_tone_generator.sv
// square wave tone generator with an axi4-lite register slave
//
// Overview of operation
// - 8-bit counter of source ticks, compared with divider
// - toggle output on divider match
// - two-bit select picks prescaler tap 32..256
// - generator runs only while enable bit set
// - full 8-bit divider range, readable back
// - square wave driven on tone pin
`timescale 1ns/100ps
`include "tone_gen_defs.svh"

module square_wave_tone_generator (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             tone_pin
);

  // ************************************************************
  // write channel
  // ************************************************************
  logic        aw_held_q, aw_held_d;
  logic [31:0] aw_addr_q, aw_addr_d;
  logic        w_held_q, w_held_d;
  logic [7:0]  w_data_q, w_data_d;
  logic        w_strb_q, w_strb_d;
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic [7:0]  divider_q, divider_d;
  logic [2:0]  control_q, control_d;
  logic        do_write;
  logic        wr_hit_div, wr_hit_ctl;

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign do_write      = aw_held_q && w_held_q && !bvalid_q;
  // word address bits [9:2] equal the 8-bit register index, so compare like widths
  assign wr_hit_div    = (aw_addr_q[`TONE_ADDR_W-1:2] == `TONE_DIVIDER_IDX) &&
                         (aw_addr_q[31:`TONE_ADDR_W] == '0);
  assign wr_hit_ctl    = (aw_addr_q[`TONE_ADDR_W-1:2] == `TONE_CONTROL_IDX) &&
                         (aw_addr_q[31:`TONE_ADDR_W] == '0);

  // address and data are captured in either order, then committed together
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d  = w_held_q;
    w_data_d  = w_data_q;
    w_strb_d  = w_strb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    divider_d = divider_q;
    control_d = control_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_strb_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = `TONE_RESP_OKAY;
      // only byte lane 0 carries register bits; other lanes are ignored
      if (wr_hit_div) begin
        if (w_strb_q) divider_d = w_data_q; // any value 00..ff accepted
      end else if (wr_hit_ctl) begin
        if (w_strb_q) control_d = w_data_q[2:0];
      end else begin
        bresp_d = `TONE_RESP_SLVERR;
      end
    end
    if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_held_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_strb_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= 2'h0;
      divider_q <= `TONE_DIVIDER_RESET;
      control_q <= 3'(`TONE_CONTROL_RESET);
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q  <= w_held_d;
      w_data_q  <= w_data_d;
      w_strb_q  <= w_strb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      divider_q <= divider_d;
      control_q <= control_d;
    end
  end

  // ************************************************************
  // read channel
  // ************************************************************
  logic        rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  rresp_q, rresp_d;
  logic        rd_hit_div, rd_hit_ctl;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_hit_div    = (s_axi_araddr[`TONE_ADDR_W-1:2] == `TONE_DIVIDER_IDX) &&
                         (s_axi_araddr[31:`TONE_ADDR_W] == '0);
  assign rd_hit_ctl    = (s_axi_araddr[`TONE_ADDR_W-1:2] == `TONE_CONTROL_IDX) &&
                         (s_axi_araddr[31:`TONE_ADDR_W] == '0);

  // one read at a time; answer comes one cycle after the address is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `TONE_RESP_OKAY;
      if (rd_hit_div) begin
        rdata_d = {24'h00_0000, divider_q}; // divider reads back as written
      end else if (rd_hit_ctl) begin
        rdata_d = {29'h0000_0000, control_q};
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = `TONE_RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= 2'h0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end
  end

  // ************************************************************
  // prescaler, tone counter and output
  // ************************************************************
  logic                     enable;
  tone_gen_pkg::tap_sel_t   tap;
  logic [`TONE_PRESC_W-1:0] presc_q, presc_d;
  logic [7:0]               count_q, count_d;
  logic                     tone_q, tone_d;
  logic                     tick;

  assign enable   = control_q[`TONE_EN_BIT];
  assign tap      = tone_gen_pkg::tap_sel_t'(control_q[`TONE_CKSEL_HI:`TONE_CKSEL_LO]);
  assign tone_pin = tone_q;

  // tick is a one-cycle enable at the selected prescaler rate
  always_comb begin
    case (tap)
      tone_gen_pkg::TAP_DIV32:  tick = presc_q[4:0] == 5'h1f;
      tone_gen_pkg::TAP_DIV64:  tick = presc_q[5:0] == 6'h3f;
      tone_gen_pkg::TAP_DIV128: tick = presc_q[6:0] == 7'h7f;
      tone_gen_pkg::TAP_DIV256: tick = presc_q == 8'hff;
      default:                  tick = 1'b0;
    endcase
  end

  // disabling restarts the prescaler too, so the first half-period is whole
  always_comb begin
    presc_d = presc_q;
    count_d = count_q;
    tone_d  = tone_q;
    if (!enable) begin
      presc_d = '0;
      count_d = 8'h00;
      tone_d  = 1'b0;
    end else begin
      presc_d = presc_q + 1'b1;
      if (tick) begin
        if (count_q == divider_q) begin
          count_d = 8'h00;
          tone_d  = !tone_q; // half period of (divider+1) ticks
        end else begin
          count_d = count_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= '0;
      count_q <= 8'h00;
      tone_q  <= 1'b0;
    end else begin
      presc_q <= presc_d;
      count_q <= count_d;
      tone_q  <= tone_d;
    end
  end

endmodule : square_wave_tone_generator

// File: tone_gen_assertions.sv
// checker for the tone generator bus and pin timing
`timescale 1ns/100ps
module tone_gen_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        tone_pin
);
  // ****
  // properties, all in the aclk domain
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_read_take;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  sequence s_read_wait;
    s_axi_rvalid && !s_axi_rready;
  endsequence
  a_read_answer: assert property (s_read_take |=> s_axi_rvalid) else $error("read not answered");
  a_read_hold: assert property (s_read_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready while busy");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  // a fresh start keeps the pin low for 8 cycles, a quarter of the shortest half period
  a_pin_quiet: assert property ($rose(aresetn) |-> !tone_pin [*8]) else $error("pin moved after reset");
  a_low_half: assert property ($fell(tone_pin) |-> !tone_pin [*8]) else $error("low half too short");
endmodule : tone_gen_assertions

bind square_wave_tone_generator tone_gen_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .tone_pin(tone_pin));

// File: tone_listener.sv
// buzzer model that measures the half periods seen on the tone pin
`timescale 1ns/100ps
module tone_listener (
  input wire logic   aclk,
  input wire logic   aresetn,
  input wire logic   tone_pin,
  output logic [31:0] half_q,
  output logic [31:0] edges_q
);
  logic [31:0] run_q;
  logic        last_q;
  // count clocks between pin changes; result lags the pin by one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {run_q, half_q, edges_q, last_q} <= '0;
    end else begin
      last_q <= tone_pin;
      run_q  <= (tone_pin != last_q) ? 32'h0 : run_q + 32'h1;
      if (tone_pin != last_q) begin
        half_q  <= run_q + 32'h1;
        edges_q <= edges_q + 32'h1;
      end
    end
  end
endmodule : tone_listener

// File: tb_top.sv
// self-checking bench for the tone generator
`timescale 1ns/100ps
`include "tone_gen_defs.svh"
module tb_top;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, half, edges, e;
  logic [3:0]  wstrb = 0, strb = 4'h1;
  logic [1:0]  bresp, rresp, sel;
  logic        awready, wready, bvalid, arready, rvalid, tone_pin;
  logic [15:0] rnd = 16'h1957;
  logic [7:0]  d;
  int err_total = 0, tests_run = 0, cyc = 0;
  localparam logic [31:0] DIV = {22'h0, `TONE_DIVIDER_ADDR}, CTL = {22'h0, `TONE_CONTROL_ADDR};
  always #5 aclk = ~aclk;
  square_wave_tone_generator dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .tone_pin(tone_pin));
  tone_listener buzzer (.aclk(aclk), .aresetn(aresetn), .tone_pin(tone_pin), .half_q(half), .edges_q(edges));
  // ****
  // helpers
  // ****
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next
  function automatic logic [31:0] exp_half(input logic [1:0] s, input logic [7:0] dv);
    return (32'h20 << s) * ({24'h0, dv} + 32'h1);
  endfunction : exp_half
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ready is looked at before the edge so the edge itself takes the item
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ta, tw;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, v, strb};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
    end while (!(ta || !awvalid) || !(tw || !wvalid));
    do @(negedge aclk); while (!bvalid);
    r = bresp;
    @(posedge aclk);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 0;
    do @(negedge aclk); while (!rvalid);
    {v, r} = {rdata, rresp};
    @(posedge aclk);
    rready <= 0;
  endtask : rd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // cut a hang short well above the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      stop_test();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(DIV, v, r); chk(v, 32'hff);
    rd(CTL, v, r); chk(v, 32'h0);
    rd(32'h100, v, r); chk({v[29:0], r}, {30'h0, `TONE_RESP_SLVERR});
    wr(32'h104, 32'h1, r); chk(r, `TONE_RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      rnd = lfsr_next(rnd);
      sel = 2'(i);
      d = (i == 0) ? 8'h00 : (i == 4) ? 8'hff : {5'h0, rnd[2:0]};
      wr(CTL, 32'h0, r);
      wr(DIV, {24'h0, d}, r); chk(r, `TONE_RESP_OKAY);
      rd(DIV, v, r); chk(v, {24'h0, d});
      chk(r, `TONE_RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk(tone_pin, 1'b0);
      e = edges;
      wr(CTL, {29'h0, sel, 1'b1}, r);
      rd(CTL, v, r); chk(v, {29'h0, sel, 1'b1});
      while (edges < e + 2) @(posedge aclk);
      chk(half, exp_half(sel, d));
    end
    rd(DIV, v, r); chk(v, 32'hff);
    // a write with lane 0 strobed off must leave the divider alone
    strb = 4'he;
    wr(DIV, 32'h5a, r); chk(r, `TONE_RESP_OKAY);
    strb = 4'h1;
    rd(DIV, v, r); chk(v, 32'hff);
    wr(CTL, 32'h0, r);
    repeat (2) @(posedge aclk);
    e = edges;
    repeat (600) @(posedge aclk);
    chk(edges, e);
    chk(tone_pin, 1'b0);
    stop_test();
  end
endmodule : tb_top
